// ---- core/acs_pkg.sv ----
// constants, states and carriers of the ADC conversion sequencer
package acs_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	// master clock pin still low this long means it is tied low, not toggling
	localparam int MCLK_STILL_NS = 1000;
	localparam int MCLK_STILL_CYC = (MCLK_STILL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// internal oscillator period, built from the system clock
	localparam int OSC_PERIOD_NS = 60;
	localparam int OSC_DIV_CYC = (OSC_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
		OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int STILL_W = 8;
	localparam int OSC_W = 3;
	localparam logic [STILL_W-1:0] STILL_LAST = STILL_W'(MCLK_STILL_CYC - 1);
	localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV_CYC - 1);

	// ------------------------------------------------------------
	// conversion timing, in master clock ticks
	// ------------------------------------------------------------
	localparam int CONVERT_REQUEST_N_TICKS = 80;
	localparam int START_LAG_TICKS = 2;
	localparam int RDY_EARLY_TICKS = 2;
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] CONVERT_REQUEST_N_LAST = CNT_W'(CONVERT_REQUEST_N_TICKS - 1);
	localparam logic [CNT_W-1:0] LAG_LAST = CNT_W'(START_LAG_TICKS - 1);
	localparam logic [CNT_W-1:0] RDY_EARLY_AT = CNT_W'(CONVERT_REQUEST_N_TICKS - 1 - RDY_EARLY_TICKS);

	// ------------------------------------------------------------
	// result coding
	// ------------------------------------------------------------
	localparam int RESULT_W = 16;
	localparam int SAMPLE_W = 20;
	localparam int ACC_W = 27;
	localparam int ACC_SHIFT = 6;
	localparam logic [RESULT_W-1:0] POS_FULL = 16'h7FFF;
	localparam logic [RESULT_W-1:0] NEG_FULL = 16'h8000;
	localparam logic [RESULT_W-1:0] SIGN_FLIP = 16'h8000;
	localparam logic [RESULT_W-1:0] UNI_TOP = 16'hFFFF;
	localparam logic [RESULT_W-1:0] UNI_BOTTOM = 16'h0000;

	// ------------------------------------------------------------
	// states and carriers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ACS_IDLE = 2'b00,
		ACS_ARM = 2'b01,
		ACS_CONVERT_REQUEST_N = 2'b11
	} acs_state_e;

	typedef struct packed {
		logic convert_request_n;
		logic mclk;
		logic portSelectN;
		logic coding_select;
	} acs_pins_s;

	// idle pin levels: request high, clock low, port deselected, unipolar
	localparam logic [3:0] PINS_IDLE = 4'hA;

	typedef struct packed {
		logic valid;
		logic [SAMPLE_W-1:0] data;
	} acs_sample_s;

	typedef struct packed {
		logic dataReadyN;
		logic oscRun;
		logic busy;
	} acs_status_s;

endpackage

// ---- core/acs_pin_sync.sv ----
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module acs_pin_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// pins
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1, s2, s3;
	logic [W-1:0] next_dout;

	// s1 feeds s2 only; agreement filters a single-cycle glitch
	always_comb begin
		next_dout = (s2 & s3) | (dout & (s2 ^ s3));
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			dout <= next_dout;
		end
	end
endmodule

// ---- core/acs_conversion_sequencer.sv ----
// conversion sequencer: clock source, conversion timing, result load, data-ready
`timescale 1ns/1ps
module acs_conversion_sequencer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// host pins, asynchronous
	input wire acs_pkg::acs_pins_s pinsAsync,
	// serial port: last bit of the word has left
	input wire logic wordShiftedOut,
	// filter output, one sample per valid
	input wire acs_pkg::acs_sample_s filterSample,
	// status and port word
	output acs_pkg::acs_status_s status,
	output logic [acs_pkg::RESULT_W-1:0] portWord
);
	import acs_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	acs_pins_s pinsS;
	logic convLow;
	logic portSelLow;

	// a request that already lines up with the clock passes unchanged
	acs_pin_sync #(
		.W($bits(acs_pins_s)),
		.RST_VAL(PINS_IDLE)
	) uPinSync (
		.clk_sys(clk_sys),
		.srst(srst),
		.din(pinsAsync),
		.dout(pinsS)
	);

	assign convLow = ~pinsS.convert_request_n;
	assign portSelLow = ~pinsS.portSelectN;

	// ------------------------------------------------------------
	// conversion clock source
	// ------------------------------------------------------------
	logic mclkPrev, next_mclkPrev;
	logic oscRun, next_oscRun;
	logic [STILL_W-1:0] stillCnt, next_stillCnt;
	logic [OSC_W-1:0] oscCnt, next_oscCnt;
	logic extTick, oscTick, tick;

	always_comb begin
		next_mclkPrev = pinsS.mclk;
		next_stillCnt = stillCnt;
		next_oscRun = oscRun;
		extTick = mclkPrev & ~pinsS.mclk;
		if (pinsS.mclk != mclkPrev) begin
			next_stillCnt = '0;
			next_oscRun = 1'b0;
		end else if (pinsS.mclk) begin
			next_oscRun = 1'b0;
		end else if (stillCnt == STILL_LAST) begin
			next_oscRun = 1'b1;
		end else begin
			next_stillCnt = stillCnt + 1'b1;
		end
		oscTick = oscRun && (oscCnt == OSC_LAST);
		next_oscCnt = (!oscRun || oscTick) ? '0 : oscCnt + 1'b1;
		// pin held high gives no ticks at all, so cycles are deleted
		tick = oscRun ? oscTick : extTick;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mclkPrev <= 1'b0;
			oscRun <= 1'b0;
			stillCnt <= '0;
			oscCnt <= '0;
		end else begin
			mclkPrev <= next_mclkPrev;
			oscRun <= next_oscRun;
			stillCnt <= next_stillCnt;
			oscCnt <= next_oscCnt;
		end
	end

	// ------------------------------------------------------------
	// result coding
	// ------------------------------------------------------------
	logic signed [ACC_W-1:0] acc, next_acc;
	logic signed [ACC_W-1:0] accScaled;
	logic accFits;
	logic signed [ACC_W-1:0] accSum;
	logic accOvf;
	logic [RESULT_W-1:0] bipWord, resultWord;

	function automatic logic signed [ACC_W-1:0] acs_widen(input logic [SAMPLE_W-1:0] s);
		acs_widen = {{(ACC_W - SAMPLE_W){s[SAMPLE_W-1]}}, s};
	endfunction

	always_comb begin
		accScaled = acc >>> ACC_SHIFT;
		accFits = (&accScaled[ACC_W-1:RESULT_W-1]) | ~(|accScaled[ACC_W-1:RESULT_W-1]);
		if (accFits) begin
			bipWord = accScaled[RESULT_W-1:0];
		end else if (accScaled[ACC_W-1]) begin
			bipWord = NEG_FULL;
		end else begin
			bipWord = POS_FULL;
		end
		// flipping the sign bit keeps the clamp: FFFF and 0000 fall out
		resultWord = pinsS.coding_select ? bipWord : bipWord ^ SIGN_FLIP;
	end

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	acs_state_e state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic dataReadyN, next_dataReadyN;
	logic busy, next_busy;
	logic [RESULT_W-1:0] next_portWord;
	logic convEnd, startConv, earlyRelease;

	always_comb begin
		convEnd = (state == ACS_CONVERT_REQUEST_N) && tick && (cnt == CONVERT_REQUEST_N_LAST);
		startConv = tick && (((state == ACS_ARM) && (cnt == LAG_LAST)) || (convEnd && convLow));
		earlyRelease = (state == ACS_CONVERT_REQUEST_N) && tick && (cnt == RDY_EARLY_AT) &&
			!dataReadyN && portSelLow;
		accSum = acc + acs_widen(filterSample.data);
		accOvf = (acc[ACC_W-1] == filterSample.data[SAMPLE_W-1]) &&
			(accSum[ACC_W-1] != acc[ACC_W-1]);
		next_state = state;
		next_cnt = cnt;
		unique case (state)
			ACS_IDLE: begin
				// from reset with request low the start lands on a fixed tick
				if (convLow) begin
					next_state = ACS_ARM;
					next_cnt = '0;
				end
			end
			ACS_ARM: begin
				// fixed lag absorbs the unknown phase of the request
				if (tick) begin
					next_cnt = cnt + 1'b1;
					if (cnt == LAG_LAST) begin
						next_state = ACS_CONVERT_REQUEST_N;
						next_cnt = '0;
					end
				end
			end
			ACS_CONVERT_REQUEST_N: begin
				if (tick) begin
					if (cnt == CONVERT_REQUEST_N_LAST) begin
						// request already high: single shot ends here
						next_state = convLow ? ACS_CONVERT_REQUEST_N : ACS_IDLE;
						next_cnt = '0;
					end else begin
						next_cnt = cnt + 1'b1;
					end
				end
			end
			default: begin
				next_state = ACS_IDLE;
				next_cnt = '0;
			end
		endcase
		next_busy = (next_state != ACS_IDLE);
		// start clears the sum so no earlier conversion leaks in
		if (startConv) begin
			next_acc = filterSample.valid ? acs_widen(filterSample.data) : '0;
		end else if ((state == ACS_CONVERT_REQUEST_N) && filterSample.valid) begin
			// clamp, never wrap: a full-scale or paused conversion keeps its sign
			next_acc = accOvf ? {acc[ACC_W-1], {(ACC_W - 1){~acc[ACC_W-1]}}} : accSum;
		end else begin
			next_acc = acc;
		end
		next_portWord = convEnd ? resultWord : portWord;
		// a new word wins over a read finishing in the same cycle
		if (convEnd) begin
			next_dataReadyN = 1'b0;
		end else if (wordShiftedOut || earlyRelease) begin
			next_dataReadyN = 1'b1;
		end else begin
			next_dataReadyN = dataReadyN;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= ACS_IDLE;
			cnt <= '0;
			acc <= '0;
			dataReadyN <= 1'b1;
			busy <= 1'b0;
			portWord <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			acc <= next_acc;
			dataReadyN <= next_dataReadyN;
			busy <= next_busy;
			portWord <= next_portWord;
		end
	end

	assign status.dataReadyN = dataReadyN;
	assign status.oscRun = oscRun;
	assign status.busy = busy;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [CNT_W-1:0] hTicks;

	// independent tick count since the last start
	always_ff @(posedge clk_sys) begin
		if (srst || startConv) begin
			hTicks <= '0;
		end else if (tick && (state == ACS_CONVERT_REQUEST_N)) begin
			hTicks <= hTicks + 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence s_end;
		convEnd;
	endsequence

	sequence s_loaded;
		!dataReadyN && (portWord == $past(resultWord));
	endsequence

	sequence s_restart;
		(state == ACS_CONVERT_REQUEST_N) && (cnt == '0);
	endsequence

	a_reset_init: assert property (disable iff (1'b0) srst |=>
		(state == ACS_IDLE) && dataReadyN && !busy)
		else $error("reset did not clear the sequencer");

	a_convert_request_n_length: assert property (s_end |-> hTicks == CONVERT_REQUEST_N_LAST)
		else $error("conversion length is not 80 ticks");

	a_single_stop: assert property (s_end ##0 !convLow |=> state == ACS_IDLE)
		else $error("single conversion did not stop");

	a_back_to_back: assert property (s_end ##0 convLow |=> s_restart)
		else $error("continuous conversion did not restart");

	a_loop_lag: assert property ((state == ACS_ARM) && tick && (cnt == LAG_LAST)
		|=> (state == ACS_CONVERT_REQUEST_N) && (hTicks == '0))
		else $error("start lag is not two ticks");

	a_arm_taken: assert property ((state == ACS_IDLE) && convLow |=> state == ACS_ARM)
		else $error("request low not taken");

	a_load_ready: assert property (s_end |=> s_loaded)
		else $error("result not loaded as ready fell");

	a_read_release: assert property (wordShiftedOut && !convEnd |=> dataReadyN)
		else $error("ready stayed low after the word was read");

	a_early_release: assert property (earlyRelease |=> dataReadyN &&
		(cnt == RDY_EARLY_AT + 1'b1))
		else $error("ready not released two ticks before end");

	a_osc_start: assert property (!pinsS.mclk && !mclkPrev &&
		(stillCnt == STILL_LAST) |=> oscRun)
		else $error("oscillator did not start on a tied-low clock");

	a_ext_clock: assert property ((pinsS.mclk != mclkPrev) |=> !oscRun)
		else $error("oscillator kept running with an external clock");

	a_held_high: assert property (pinsS.mclk |=> !oscRun)
		else $error("oscillator ran with clock pin high");

	a_bipolar_code: assert property (pinsS.coding_select && !accFits |->
		resultWord == (accScaled[ACC_W-1] ? NEG_FULL : POS_FULL))
		else $error("bipolar result not saturated");

	a_unipolar_code: assert property (!pinsS.coding_select && !accFits |->
		resultWord == (accScaled[ACC_W-1] ? UNI_BOTTOM : UNI_TOP))
		else $error("unipolar result not saturated");

	a_fresh_acc: assert property (startConv && !filterSample.valid |=> acc == '0)
		else $error("sum carried over between conversions");

endmodule

// ---- verif/acs_host_model.sv ----
// host model: master clock pin, convert request and word reads
`timescale 1ns/1ps
module acs_host_model (
	// clock
	input wire logic clk_sys,
	// bench controls: clock 0 toggle 1 low 2 high; request 0 high 1 low 2 loop
	input wire logic [1:0] mclkMode,
	input wire logic [1:0] reqMode,
	input wire logic readEn,
	// device side
	input wire logic dataReadyN,
	output logic mclk,
	output logic convertRequestN,
	output logic wordShiftedOut
);
	logic [2:0] div = '0;
	logic reqReg = 1'b1;
	logic [3:0] rdCnt = '0;
	logic mclkReg = 1'b0;
	logic shiftedReg = 1'b0;

	assign mclk = mclkReg;
	assign wordShiftedOut = shiftedReg;

	// loopback is a plain board wire, no clocking
	assign convertRequestN = (reqMode == 2'd2) ? dataReadyN : reqReg;

	always @(posedge clk_sys) begin
		#1;
		div <= div + 3'd1;
		if (mclkMode == 2'd0) begin
			if (div[1:0] == 2'd3) begin
				mclkReg <= ~mclkReg;
			end
		end else begin
			mclkReg <= mclkMode[1];
		end
		// request moves only as the clock falls while it toggles, keeping converters aligned; with the clock tied low or high it moves on any cycle
		if (mclkMode != 2'd0 || (mclkReg && div[1:0] == 2'd3)) begin
			reqReg <= (reqMode != 2'd1);
		end
		rdCnt <= (dataReadyN || !readEn) ? 4'd0 : rdCnt + 4'd1;
		shiftedReg <= readEn && !dataReadyN && rdCnt == 4'd2;
	end
endmodule

// ---- verif/acs_conversion_sequencer_tb_top.sv ----
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module acs_conversion_sequencer_tb_top;
	import acs_pkg::*;
	logic clk_sys;
	logic srst;
	logic mclk;
	logic convReqN;
	logic wordShiftedOut;
	logic [1:0] mclkMode;
	logic [1:0] reqMode;
	logic readEn;
	logic selN;
	logic coding;
	logic sampleValid = 1'b0;
	logic [SAMPLE_W-1:0] sampleData;
	acs_status_s status;
	logic [RESULT_W-1:0] portWord;
	logic prevRdy = 1'b1;
	int seed = 59279;
	int failures = 0;
	int nChecks = 0;
	int cyc = 0;
	int fallCnt = 0;
	int riseCnt = 0;
	int lastFall = 0;
	int highStart = 0;
	int interval = 0;
	int highLen = 0;
	int lowLen = 0;

	acs_conversion_sequencer acs_conversion_sequencer_inst (
		.clk_sys(clk_sys),
		.srst(srst),
		.pinsAsync({convReqN, mclk, selN, coding}),
		.wordShiftedOut(wordShiftedOut),
		.filterSample({sampleValid, sampleData}),
		.status(status),
		.portWord(portWord)
	);

	acs_host_model acs_host_model_inst (
		.clk_sys(clk_sys),
		.mclkMode(mclkMode),
		.reqMode(reqMode),
		.readEn(readEn),
		.dataReadyN(status.dataReadyN),
		.mclk(mclk),
		.convertRequestN(convReqN),
		.wordShiftedOut(wordShiftedOut)
	);

	// ----
	// helpers
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			failures++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic wait_falls(input int n, input int lim);
		int t;
		t = fallCnt + n;
		for (int i = 0; i < lim && fallCnt < t; i++) cycles(1);
		chk(32'(fallCnt >= t), 1);
	endtask

	task automatic wrap_up();
		if (failures == 0 && nChecks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// kind 0 top, 1 bottom, 2 mid-scale; unipolar flips the sign bit
	function automatic logic [15:0] exp_word(input int kind, input logic bip);
		logic [15:0] w;
		w = (kind == 0) ? 16'h7FFF : (kind == 1) ? 16'h8000 : 16'h0000;
		return bip ? w : w ^ 16'h8000;
	endfunction

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ready edge monitor, random sample strobes, hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 40000) begin
			failures++;
			wrap_up();
		end
		if (prevRdy === 1'b1 && status.dataReadyN === 1'b0) begin
			fallCnt++;
			interval = cyc - lastFall;
			highLen = cyc - highStart;
			lastFall = cyc;
		end
		if (prevRdy === 1'b0 && status.dataReadyN === 1'b1) begin
			riseCnt++;
			lowLen = cyc - lastFall;
			highStart = cyc;
		end
		prevRdy = status.dataReadyN;
		sampleValid <= #1 1'($random(seed));
	end

	// ----
	// scenarios
	// ----
	initial begin
		int kind;
		int f;
		srst = 1'b1;
		mclkMode = 2'd0;
		reqMode = 2'd0;
		readEn = 1'b1;
		selN = 1'b1;
		coding = 1'b1;
		sampleData = {2'b01, 18'($random(seed))};
		cycles(2);
		srst = 1'b0;
		cycles(1);
		chk(32'({status, portWord}), 32'({3'b100, 16'h0000}));
		reqMode = 2'd1;
		wait_falls(3, 2200);
		chk(interval, 640);
		chk(32'(portWord), 32'h0000_7FFF);
		chk(32'(lowLen < 8), 1);
		readEn = 1'b0;
		selN = 1'b0;
		wait_falls(2, 1500);
		chk(highLen, 16);
		selN = 1'b1;
		f = riseCnt;
		cycles(1400);
		chk(riseCnt - f, 0);
		readEn = 1'b1;
		reqMode = 2'd2;
		wait_falls(3, 2500);
		chk(interval, 656);
		reqMode = 2'd0;
		cycles(1400);
		for (int i = 0; i < 6; i++) begin
			kind = (i < 3) ? i : {$random(seed)} % 3;
			coding = 1'($random(seed));
			sampleData = (kind == 2) ? '0 : {kind[0], ~kind[0], 18'($random(seed))};
			f = fallCnt;
			cycles(20);
			reqMode = 2'd1;
			cycles(80);
			reqMode = 2'd0;
			wait_falls(1, 720);
			chk(32'(portWord), 32'(exp_word(kind, coding)));
			cycles(760);
			chk(fallCnt - f, 1);
			chk(32'(status.busy), 0);
		end
		mclkMode = 2'd1;
		reqMode = 2'd1;
		cycles(120);
		chk(32'(status.oscRun), 1);
		wait_falls(3, 1600);
		chk(interval, 480);
		mclkMode = 2'd2;
		cycles(10);
		f = fallCnt;
		chk(32'(status.oscRun), 0);
		cycles(1000);
		chk(fallCnt - f, 0);
		mclkMode = 2'd0;
		wait_falls(2, 1500);
		chk(32'(status.oscRun), 0);
		chk(interval, 640);
		// mid-run reset with the request still low: clean restart
		srst = 1'b1;
		cycles(2);
		srst = 1'b0;
		cycles(1);
		chk(32'({status, portWord}), 32'({3'b100, 16'h0000}));
		wait_falls(1, 800);
		chk(32'(status.busy), 1);
		wrap_up();
	end
endmodule
